// ---- hdl/hps_port.sv ----
// device end of the asynchronous host port: strobe decode, ready pacing, data latch path
// assumes host pins are asynchronous; fetch engine and write buffer run on core_clk_in

// Summary of operation
// RULE_01: strobe is xnor of data strobes, or select
// RULE_02: host holds selects around strobe fall
// RULE_03: halfword select counts only in sixteen-bit mode
// RULE_04: latch read fall starts an engine fetch
// RULE_05: ready stays high until fetched data loaded
// RULE_06: write waits with ready high while buffer full
// RULE_07: host holds strobe until ready is low
// RULE_08: address strobe pulses once per strobe period
// RULE_09: strobe low at least four periods, 12.5ns
// RULE_10: strobe high four periods between accesses
// RULE_11: ready high within four periods plus 8ns
// RULE_12: second halfword read served without new fetch
// RULE_13: drive data bus only during read strobe
module hps_port (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic sixteen_bit_host_mode_in,
  input wire logic host_chip_select_n_in,
  input wire logic host_data_strobe_one_in,
  input wire logic host_data_strobe_two_in,
  input wire logic host_addr_strobe_n_in,
  input wire hps_pkg::hps_sel_t host_sel_in,
  input wire logic [hps_pkg::DATA_W-1:0] host_data_bus_in,
  output logic [hps_pkg::DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  output logic host_ready_n_out,
  output logic fetch_req_out,
  input wire logic fetch_valid_in,
  input wire logic [hps_pkg::DATA_W-1:0] fetch_data_in,
  input wire logic wr_buf_full_in,
  output logic wr_valid_out,
  output logic [hps_pkg::DATA_W-1:0] wr_data_out
);
  import hps_pkg::*;

  // -----------------------------------------
  // pin synchronisation
  // -----------------------------------------
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_idle;
  logic [PIN_W-1:0] pins_f;
  logic mode16;
  logic cs_n_f;
  logic ds1_f;
  logic ds2_f;
  logic as_n_f;
  hps_sel_t sel_f;
  logic [DATA_W-1:0] data_f;

  assign pins_raw = {sixteen_bit_host_mode_in, host_chip_select_n_in, host_data_strobe_one_in,
                     host_data_strobe_two_in, host_addr_strobe_n_in, host_sel_in, host_data_bus_in};
  assign pins_idle = {1'b0, 1'b1, 1'b0, 1'b0, 1'b1, SEL_RESET, DATA_RESET};

  hps_sync #(.WIDTH(PIN_W)) u_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(pins_raw),
    .reset_val_in(pins_idle),
    .filt_out(pins_f)
  );

  assign {mode16, cs_n_f, ds1_f, ds2_f, as_n_f, sel_f, data_f} = pins_f;

  // -----------------------------------------
  // composite strobe and select capture
  // -----------------------------------------
  logic strobe_n;
  logic strobe_n_q;
  logic as_n_q;
  logic strobe_fall;
  logic strobe_rise;
  logic as_seen;
  hps_sel_t sel_as;
  hps_sel_t sel_take;
  hps_sel_t sel_mask;

  assign strobe_n = ~(ds1_f ^ ds2_f) | cs_n_f; // RULE_01
  assign strobe_fall = strobe_n_q & ~strobe_n;
  assign strobe_rise = ~strobe_n_q & strobe_n;

  // halfword is no select in thirty-two-bit mode
  always_comb begin
    sel_mask = as_seen ? sel_as : sel_f;
    sel_take = sel_mask;
    sel_take.halfword = mode16 & sel_mask.halfword; // RULE_03
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strobe_n_q <= 1'b1;
      as_n_q <= 1'b1;
    end else begin
      strobe_n_q <= strobe_n;
      as_n_q <= as_n_f;
    end
  end

  // address strobe, when used, latches selects once per strobe period
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      as_seen <= 1'b0;
      sel_as <= SEL_RESET;
    end else if (as_n_q && !as_n_f && (!as_seen || strobe_rise)) begin // RULE_08
      // a fall meeting a strobe rise belongs to the next period, so it wins
      as_seen <= 1'b1;
      sel_as <= sel_f;
    end else if (strobe_rise) begin
      as_seen <= 1'b0;
    end
  end

  // -----------------------------------------
  // access sequencer
  // -----------------------------------------
  hps_state_t state;
  hps_sel_t sel_cur;
  logic is_latch;
  logic [DATA_W-1:0] word_hold;
  logic [HALF_W-1:0] low_half;

  assign is_latch = (sel_take.access_type == ACC_DATA_LATCH) || (sel_take.access_type == ACC_DATA_LATCH_INC);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= HPS_IDLE;
      sel_cur <= SEL_RESET;
    end else begin
      case (state)
        HPS_IDLE: begin
          if (strobe_fall) begin
            sel_cur <= sel_take;
            if (is_latch && sel_take.read_write && !sel_take.halfword) begin
              state <= HPS_FETCH; // RULE_04
            end else if (is_latch && !sel_take.read_write && wr_buf_full_in) begin
              state <= HPS_WR_WAIT; // RULE_06
            end else begin
              state <= HPS_DONE; // RULE_12
            end
          end
        end
        HPS_FETCH: begin
          if (fetch_valid_in) begin
            state <= HPS_DONE; // RULE_05
          end
        end
        HPS_WR_WAIT: begin
          if (!wr_buf_full_in) begin
            state <= HPS_DONE; // RULE_06
          end
        end
        HPS_DONE: begin
          // strobe left early still ends the access
          if (strobe_rise || strobe_n) begin
            state <= HPS_IDLE; // RULE_07
          end
        end
        default: begin
          state <= HPS_IDLE;
        end
      endcase
    end
  end

  // ready is idle high, so a wait needs no extra edge
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_ready_n_out <= 1'b1;
    end else if (strobe_n) begin
      host_ready_n_out <= 1'b1;
    end else if (state == HPS_IDLE && strobe_fall) begin
      host_ready_n_out <= is_latch && (sel_take.read_write ? !sel_take.halfword : wr_buf_full_in); // RULE_11
    end else if (state == HPS_FETCH) begin
      host_ready_n_out <= !fetch_valid_in; // RULE_05
    end else if (state == HPS_WR_WAIT) begin
      host_ready_n_out <= wr_buf_full_in; // RULE_06
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fetch_req_out <= 1'b0;
    end else begin
      fetch_req_out <= state == HPS_IDLE && strobe_fall && is_latch && sel_take.read_write
                       && !sel_take.halfword; // RULE_04
    end
  end

  // -----------------------------------------
  // read data path
  // -----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_hold <= DATA_RESET;
      host_data_bus_out <= DATA_RESET;
    end else if (state == HPS_FETCH && fetch_valid_in) begin
      word_hold <= fetch_data_in;
      host_data_bus_out <= mode16 ? {{HALF_W{1'b0}}, fetch_data_in[HALF_W-1:0]} : fetch_data_in;
    end else if (state == HPS_IDLE && strobe_fall && sel_take.read_write) begin
      // second half comes from the word already held
      host_data_bus_out <= (is_latch && sel_take.halfword)
                           ? {{HALF_W{1'b0}}, word_hold[DATA_W-1:HALF_W]} : DATA_RESET; // RULE_12
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_data_bus_oe_out <= 1'b0;
    end else if (strobe_n) begin
      host_data_bus_oe_out <= 1'b0; // RULE_13
    end else if (state == HPS_IDLE && strobe_fall) begin
      host_data_bus_oe_out <= sel_take.read_write; // RULE_13
    end
  end

  // -----------------------------------------
  // write data path
  // -----------------------------------------
  // host data is only valid near the strobe rise, so it is taken there
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_valid_out <= 1'b0;
      wr_data_out <= DATA_RESET;
      low_half <= '0;
    end else begin
      wr_valid_out <= 1'b0;
      if (state == HPS_DONE && strobe_rise && !sel_cur.read_write
          && ((sel_cur.access_type == ACC_DATA_LATCH) || (sel_cur.access_type == ACC_DATA_LATCH_INC))) begin
        if (mode16 && !sel_cur.halfword) begin
          low_half <= data_f[HALF_W-1:0];
        end else begin
          wr_valid_out <= 1'b1;
          wr_data_out <= mode16 ? {data_f[HALF_W-1:0], low_half} : data_f;
        end
      end
    end
  end

  // -----------------------------------------
  // checks
  // -----------------------------------------
  a_strobe_cs_gate: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_01
    cs_n_f |-> strobe_n) else $error("strobe active without chip select");

  a_desel_no_fetch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_01
    cs_n_f |=> !fetch_req_out) else $error("fetch issued while deselected");

  a_halfword_mode32: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_03
    !mode16 |-> !sel_take.halfword) else $error("halfword used in 32-bit mode");

  a_mode32_read_fetch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_03
    (!mode16 && state == HPS_IDLE && strobe_fall && is_latch && sel_take.read_write) |=> fetch_req_out)
    else $error("32-bit latch read did not fetch");

  a_fetch_on_fall: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_04
    (state == HPS_IDLE && strobe_fall && is_latch && sel_take.read_write && !sel_take.halfword)
    |=> fetch_req_out && state == HPS_FETCH ##1 !fetch_req_out) else $error("fetch not issued once");

  a_fetch_ready_hi: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_05
    (state == HPS_FETCH && !fetch_valid_in) |=> host_ready_n_out) else $error("ready low before data");

  a_fetch_done: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_05
    (state == HPS_FETCH && fetch_valid_in && !strobe_n) |=> !host_ready_n_out && host_data_bus_oe_out)
    else $error("fetched data not presented");

  a_wr_full_wait: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_06
    (state == HPS_WR_WAIT && wr_buf_full_in) |=> host_ready_n_out && state == HPS_WR_WAIT)
    else $error("write accepted while buffer full");

  a_wait_ready_hi: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_11
    strobe_fall |-> host_ready_n_out ##1 (host_ready_n_out || state == HPS_DONE))
    else $error("ready not high at strobe fall");

  a_second_half: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_12
    (state == HPS_IDLE && strobe_fall && is_latch && sel_take.read_write && sel_take.halfword)
    |=> !fetch_req_out && host_data_bus_oe_out && !host_ready_n_out
        && host_data_bus_out == {{HALF_W{1'b0}}, $past(word_hold[DATA_W-1:HALF_W])})
    else $error("second half not served at once");

  a_bus_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_13
    strobe_n |=> !host_data_bus_oe_out) else $error("data bus driven after strobe");

endmodule // hps_port

// ---- hdl/hps_pkg.sv ----
// shared constants and types of the host port strobe/ready handshake
// assumes one 100 MHz core clock and an asynchronous host on the pins
package hps_pkg;

  // -----------------------------------------
  // timing
  // -----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_LOW_MIN_PERIODS = 4;
  localparam real STROBE_LOW_MIN_NS = 12.5;
  localparam int READY_WAIT_MAX_ADD_NS = 8;
  // longest time: round down, at least one cycle
  localparam int READY_WAIT_MAX_NS = STROBE_LOW_MIN_PERIODS * CLK_PERIOD_NS + READY_WAIT_MAX_ADD_NS;
  localparam int READY_WAIT_MAX_CYC = (READY_WAIT_MAX_NS / CLK_PERIOD_NS < 1) ? 1
                                      : READY_WAIT_MAX_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;

  // -----------------------------------------
  // widths and encodings
  // -----------------------------------------
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam logic [1:0] ACC_DATA_LATCH_INC = 2'h1;
  localparam logic [1:0] ACC_DATA_LATCH = 2'h3;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

  typedef struct packed {
    logic [1:0] access_type;
    logic read_write;
    logic halfword;
  } hps_sel_t;

  localparam hps_sel_t SEL_RESET = 4'h0;
  localparam int PIN_W = DATA_W + 5 + $bits(hps_sel_t);

  typedef enum {
    HPS_IDLE,
    HPS_FETCH,
    HPS_WR_WAIT,
    HPS_DONE
  } hps_state_t;

endpackage

// ---- hdl/hps_sync.sv ----
// three-stage pin synchroniser with agreement filter
// assumes inputs asynchronous to clk_in; output changes only when stages two and three agree
module hps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] reset_val_in,
  output logic [WIDTH-1:0] filt_out
);
  import hps_pkg::*;

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] held;
  logic [1:0] fill;
  logic seeded;

  // -----------------------------------------
  // per-bit stages
  // -----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          stage1[gi] <= 1'b0;
          stage2[gi] <= 1'b0;
          stage3[gi] <= 1'b0;
        end else begin
          stage1[gi] <= pin_in[gi];
          stage2[gi] <= stage1[gi];
          stage3[gi] <= stage2[gi];
        end
      end
      // combinational so the core sees a change one edge after the stages agree
      // idle level stands in until stage three holds a real sample, so no false edge follows reset
      assign filt_out[gi] = !seeded ? reset_val_in[gi] : (stage2[gi] == stage3[gi]) ? stage3[gi] : held[gi];
    end
  endgenerate

  assign seeded = (fill == 2'(SYNC_STAGES));

  // stages reset to zero, so the idle levels mask them until every stage is filled
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held <= '0;
      fill <= 2'h0;
    end else begin
      held <= filt_out;
      if (!seeded) begin
        fill <= fill + 2'h1;
      end
    end
  end

endmodule // hps_sync

// ---- verif/hps_host.sv ----
// host processor model: drives strobe, select and data pins of the port
// assumes xfer is called by one process at a time, on the core clock
module hps_host (
  input wire logic clk_in,
  input wire logic ready_n_in,
  input wire logic [hps_pkg::DATA_W-1:0] bus_in,
  input wire logic oe_in,
  output logic cs_n_out,
  output logic ds1_out,
  output logic ds2_out,
  output logic as_n_out,
  output hps_pkg::hps_sel_t sel_out,
  output logic [hps_pkg::DATA_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import hps_pkg::*;

  initial begin
    cs_n_out = 1'b1;
    ds1_out = 1'b0;
    ds2_out = 1'b0;
    as_n_out = 1'b1;
    sel_out = SEL_RESET;
    data_out = 32'h5A5A5A5A;
  end

  // ---------------------------------------------
  // one access: selects, strobe fall, wait ready
  // ---------------------------------------------
  task automatic xfer(input logic csn, input logic swap, input logic use_as, input hps_sel_t sel,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output int n,
                      output logic oe_seen);
    logic ok;
    @(posedge clk_in);
    sel_out <= sel;
    // idle data lines flip so a stale value is never mistaken for a driven one
    data_out <= sel.read_write ? ~data_out : wd;
    as_n_out <= ~use_as;
    @(posedge clk_in);
    cs_n_out <= csn;
    ds1_out <= swap;
    ds2_out <= ~swap;
    n = 0;
    ok = 1'b0;
    while (n < 60 && !ok) begin
      @(posedge clk_in);
      n++;
      if (n == 2) begin
        as_n_out <= 1'b1;
        // selects only need to stand around the address strobe fall
        if (use_as) sel_out <= ~sel;
      end
      ok = (ready_n_in === 1'b0);
    end
    rd = bus_in;
    oe_seen = oe_in;
    if (n < 4) repeat (4 - n) @(posedge clk_in);
    ds1_out <= 1'b0;
    ds2_out <= 1'b0;
    cs_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // hps_host

// ---- verif/tb.sv ----
// self-checking bench of the host port; engine and write sink are behavioural
// assumes one 100 MHz clock and reset held for four cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hps_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mode16 = 1'b0;
  logic fvalid = 1'b0;
  logic full = 1'b0;
  logic [DATA_W-1:0] fdata = 32'h0;
  logic cs_n, ds1, ds2, as_n, oe, rdy_n, freq, wv, oe_seen;
  hps_sel_t sel;
  logic [DATA_W-1:0] hd_in, hd_out, wd, rd, last_wr;
  int n_fail = 0, cmp_count = 0, n_fetch = 0, n_wr = 0, f_cnt = 0, n, f0, w0;
  int f_delay = 10;

  always #5 core_clk_in = ~core_clk_in;

  hps_port hps_port_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sixteen_bit_host_mode_in(mode16),
    .host_chip_select_n_in(cs_n), .host_data_strobe_one_in(ds1), .host_data_strobe_two_in(ds2),
    .host_addr_strobe_n_in(as_n), .host_sel_in(sel), .host_data_bus_in(hd_in), .host_data_bus_out(hd_out),
    .host_data_bus_oe_out(oe), .host_ready_n_out(rdy_n), .fetch_req_out(freq), .fetch_valid_in(fvalid),
    .fetch_data_in(fdata), .wr_buf_full_in(full), .wr_valid_out(wv), .wr_data_out(wd));
  hps_host hps_host_i (.clk_in(core_clk_in), .ready_n_in(rdy_n), .bus_in(hd_out), .oe_in(oe), .cs_n_out(cs_n),
    .ds1_out(ds1), .ds2_out(ds2), .as_n_out(as_n), .sel_out(sel), .data_out(hd_in));

  // ---------------------------------------------
  // transfer engine and write sink
  // ---------------------------------------------
  always @(posedge core_clk_in) begin
    if (freq === 1'b1) begin
      n_fetch <= n_fetch + 1;
      f_cnt <= f_delay;
    end else if (f_cnt > 0) begin
      f_cnt <= f_cnt - 1;
      fvalid <= (f_cnt == 1);
    end
    if (rdy_n === 1'b0) fvalid <= 1'b0;
    if (wv === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= wd;
    end
  end

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic csn, swap, use_as, rw, hw, input logic [1:0] t, input logic [DATA_W-1:0] w);
    hps_host_i.xfer(csn, swap, use_as, hps_sel_t'({t, rw, hw}), w, rd, n, oe_seen);
  endtask

  task automatic t_rd32();
    for (int i = 0; i < 2; i++) begin
      f0 = n_fetch;
      fdata <= i ? 32'h3C96F00D : 32'hA5C31E7F;
      acc(1'b0, i[0], i[0], 1'b1, i[0], i ? ACC_DATA_LATCH_INC : ACC_DATA_LATCH, 32'h0);
      chk("read word", i ? 32'h3C96F00D : 32'hA5C31E7F, rd);
      chk("fetch count", 32'h1, 32'(n_fetch - f0));
      chk("ready held for engine", 32'h1, {31'h0, n > f_delay + 4});
      chk("bus driven", 32'h1, {31'h0, oe_seen});
      chk("bus released", 32'h0, {31'h0, oe});
    end
  endtask

  task automatic t_rd16();
    mode16 <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    f0 = n_fetch;
    fdata <= 32'h8E214B77;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, ACC_DATA_LATCH, 32'h0);
    chk("first half", 32'h4B77, {16'h0, rd[15:0]});
    fdata <= 32'h0;
    acc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, ACC_DATA_LATCH, 32'h0);
    chk("second half", 32'h8E21, {16'h0, rd[15:0]});
    chk("one fetch per word", 32'h1, 32'(n_fetch - f0));
    chk("second half prompt", 32'h1, {31'h0, n <= READY_WAIT_MAX_CYC + 1});
  endtask

  task automatic t_wr16();
    w0 = n_wr;
    acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ACC_DATA_LATCH, 32'h7777C0DE);
    full <= 1'b1;
    fork
      acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ACC_DATA_LATCH, 32'h0000BEEF);
      begin
        repeat (15) @(posedge core_clk_in);
        full <= 1'b0;
      end
    join
    chk("write held while full", 32'h1, {31'h0, n >= 12});
    chk("words pushed", 32'h1, 32'(n_wr - w0));
    chk("write word", 32'hBEEFC0DE, last_wr);
  endtask

  task automatic t_misc();
    mode16 <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, ACC_DATA_LATCH, 32'h13579BDF);
    chk("write prompt", 32'h1, {31'h0, n <= READY_WAIT_MAX_CYC + 1});
    chk("write word 32", 32'h13579BDF, last_wr);
    f0 = n_fetch;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 32'h0);
    chk("other access reads zero", 32'h0, rd);
    chk("other access prompt", 32'h1, {31'h0, n <= READY_WAIT_MAX_CYC + 1});
    acc(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, ACC_DATA_LATCH, 32'h0);
    chk("deselected ignored", 32'h1, {31'h0, n == 60});
    chk("deselected bus idle", 32'h0, {31'h0, oe_seen});
    chk("no fetch", 32'h0, 32'(n_fetch - f0));
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_rd32();
    t_rd16();
    t_wr16();
    t_misc();
    results();
  end

  // whole run needs about 250 cycles; this is a generous ceiling
  initial begin
    #200us;
    n_fail++;
    results();
  end
endmodule // tb
